/* rtl/cws_startup.sv */
// Configuration word store, feature decode and start-up reset sequencer
`timescale 1ns/1ps
module cws_startup
#(
    parameter int POWER_UP_DELAY_TIMER_CYCLES = cws_pkg::POWER_UP_DELAY_TIMER_CYCLES,
    parameter int OST_TICKS   = cws_pkg::OST_TICKS
)
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ext_reset_pin_n,
    input  wire logic              brownout_det,
    input  wire logic              osc_pin,
    input  wire logic              sw_brownout_en,
    input  wire logic              sw_watchdog_en,
    input  wire logic              sleep_req,
    input  wire logic              watchdog_wake,
    input  wire logic              irq_wake,
    input  wire logic              prog_mode,
    input  wire logic              prog_wr,
    input  wire logic              prog_rd,
    input  wire logic [13:0]       prog_addr,
    input  wire logic [15:0]       prog_wdata,
    output logic [15:0]            prog_rdata,
    output logic                   prog_ack,
    output cws_pkg::cws_feat_t     feat,
    output logic                   core_reset,
    output logic                   sleeping,
    output logic                   ext_pin_data
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, change accepted when stages two and three agree

    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync3_r;
    logic [2:0] filt_r;
    logic [2:0] filt_nxt;
    logic       osc_prev_r;
    logic       osc_edge;

    always_comb
    begin
        filt_nxt = (~(sync2_r ^ sync3_r) & sync3_r)
                 | ((sync2_r ^ sync3_r) & filt_r);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sync1_r    <= cws_pkg::SYNC_RST;
            sync2_r    <= cws_pkg::SYNC_RST;
            sync3_r    <= cws_pkg::SYNC_RST;
            filt_r     <= cws_pkg::SYNC_RST;
            osc_prev_r <= 1'b0;
        end
        else
        begin
            sync1_r    <= {osc_pin, brownout_det, ext_reset_pin_n};
            sync2_r    <= sync1_r;
            sync3_r    <= sync2_r;
            filt_r     <= filt_nxt;
            osc_prev_r <= filt_r[2];
        end
    end

    assign osc_edge = filt_r[2] & ~osc_prev_r;

    ////////////////////////////////////////////////////////////////////////
    // Configuration word and programming port

    logic [15:0] cfg_r;
    logic [15:0] cfg_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic        in_cfg_space;

    assign in_cfg_space = (prog_addr >= cws_pkg::CFG_SPACE_LO)
                       && (prog_addr <= cws_pkg::CFG_SPACE_HI);

    always_comb
    begin
        cfg_nxt   = cfg_r;
        rdata_nxt = rdata_r;
        ack_nxt   = 1'b0;
        if (prog_mode && (prog_wr || prog_rd))
        begin
            ack_nxt = 1'b1;
            if (prog_wr && prog_addr == cws_pkg::CFG_ADDR)
                cfg_nxt = prog_wdata | cws_pkg::CFG_UNIMPL;
            if (prog_rd)
                rdata_nxt = (in_cfg_space
                             && prog_addr == cws_pkg::CFG_ADDR)
                            ? cfg_r : cws_pkg::CFG_UNMAPPED;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cfg_r   <= cws_pkg::CFG_ERASED;
            rdata_r <= cws_pkg::CFG_UNMAPPED;
            ack_r   <= 1'b0;
        end
        else
        begin
            cfg_r   <= cfg_nxt;
            rdata_r <= rdata_nxt;
            ack_r   <= ack_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Feature decode

    cws_pkg::cws_feat_t feat_r;
    cws_pkg::cws_feat_t feat_nxt;
    logic               sleeping_r;

    always_comb
    begin
        feat_nxt = cws_pkg::cws_decode(cfg_r, sleeping_r,
                                       sw_brownout_en, sw_watchdog_en);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            feat_r <= cws_pkg::cws_decode(cws_pkg::CFG_ERASED, 1'b0,
                                          1'b0, 1'b0);
        else
            feat_r <= feat_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Start-up sequencer

    cws_pkg::cws_state_t state_r;
    cws_pkg::cws_state_t state_nxt;
    logic                delay_pend_r;
    logic                delay_pend_nxt;
    logic                core_reset_r;
    logic                pin_r;
    logic                ext_rst;
    logic                bor_trip;
    logic                any_reset;
    logic                power_up_delay_timer_done;
    logic                ost_done;

    assign ext_rst   = feat_r.ext_reset_pin_select & ~filt_r[0];
    assign bor_trip  = feat_r.brownout_en & filt_r[1];
    assign any_reset = ext_rst | bor_trip | prog_mode;

    always_comb
    begin
        state_nxt      = state_r;
        delay_pend_nxt = delay_pend_r | bor_trip;
        if (any_reset)
            state_nxt = cws_pkg::ST_HOLD;
        else
            case (state_r)
                cws_pkg::ST_HOLD:
                begin
                    delay_pend_nxt = 1'b0;
                    if (delay_pend_r && feat_r.power_up_delay_en)
                        state_nxt = cws_pkg::ST_POWER_UP_DELAY_TIMER;
                    else if (feat_r.crystal_mode)
                        state_nxt = cws_pkg::ST_OST;
                    else
                        state_nxt = cws_pkg::ST_RUN;
                end
                cws_pkg::ST_POWER_UP_DELAY_TIMER:
                    if (power_up_delay_timer_done)
                        state_nxt = feat_r.crystal_mode
                                  ? cws_pkg::ST_OST
                                  : cws_pkg::ST_RUN;
                cws_pkg::ST_OST:
                    if (ost_done)
                        state_nxt = cws_pkg::ST_RUN;
                cws_pkg::ST_RUN:
                    if (sleep_req)
                        state_nxt = cws_pkg::ST_SLEEP;
                cws_pkg::ST_SLEEP:
                    if (watchdog_wake || irq_wake)
                        state_nxt = cws_pkg::ST_RUN;
                default:
                    state_nxt = cws_pkg::ST_HOLD;
            endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r      <= cws_pkg::ST_HOLD;
            delay_pend_r <= 1'b1;
            core_reset_r <= 1'b1;
            sleeping_r   <= 1'b0;
            pin_r        <= 1'b1;
        end
        else
        begin
            state_r      <= state_nxt;
            delay_pend_r <= delay_pend_nxt;
            core_reset_r <= (state_nxt != cws_pkg::ST_RUN)
                         && (state_nxt != cws_pkg::ST_SLEEP);
            sleeping_r   <= (state_nxt == cws_pkg::ST_SLEEP);
            pin_r        <= filt_r[0];
        end
    end

    cws_delay u_power_up_delay_timer
    (
        .clk   (clk),
        .rst   (rst),
        .clear (state_r != cws_pkg::ST_POWER_UP_DELAY_TIMER),
        .tick  (1'b1),
        .limit (cws_pkg::CNT_W'(POWER_UP_DELAY_TIMER_CYCLES)),
        .done  (power_up_delay_timer_done)
    );

    cws_delay u_ost
    (
        .clk   (clk),
        .rst   (rst),
        .clear (state_r != cws_pkg::ST_OST),
        .tick  (osc_edge),
        .limit (cws_pkg::CNT_W'(OST_TICKS)),
        .done  (ost_done)
    );

    assign prog_rdata   = rdata_r;
    assign prog_ack     = ack_r;
    assign feat         = feat_r;
    assign core_reset   = core_reset_r;
    assign sleeping     = sleeping_r;
    assign ext_pin_data = pin_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    logic [cws_pkg::CNT_W-1:0] power_up_delay_timer_cyc_r;

    always_ff @(posedge clk)
    begin
        if (rst || state_r == cws_pkg::ST_HOLD)
            power_up_delay_timer_cyc_r <= '0;
        else if (state_r == cws_pkg::ST_POWER_UP_DELAY_TIMER)
            power_up_delay_timer_cyc_r <= power_up_delay_timer_cyc_r + 1'b1;
    end

    power_up_delay_timer_length_a: assert property (@(posedge clk) disable iff (rst)
        (state_r == cws_pkg::ST_POWER_UP_DELAY_TIMER && state_nxt != cws_pkg::ST_POWER_UP_DELAY_TIMER
         && !any_reset) |-> power_up_delay_timer_cyc_r == cws_pkg::CNT_W'(POWER_UP_DELAY_TIMER_CYCLES))
        else $error("power-up delay length wrong");

    ost_hold_a: assert property (@(posedge clk) disable iff (rst)
        (state_r == cws_pkg::ST_OST && !ost_done) |=> core_reset_r)
        else $error("released before oscillator start-up");

    bor_reset_a: assert property (@(posedge clk) disable iff (rst)
        bor_trip |=> core_reset_r && state_r == cws_pkg::ST_HOLD)
        else $error("brown-out did not reset");

    sleep_wake_a: assert property (@(posedge clk) disable iff (rst)
        (sleeping_r && (watchdog_wake || irq_wake) && !any_reset)
        |=> !sleeping_r && !core_reset_r)
        else $error("sleep not left on wake event");

    cfg_write_a: assert property (@(posedge clk) disable iff (rst)
        (prog_mode && prog_wr && prog_addr == cws_pkg::CFG_ADDR)
        |=> cfg_r == ($past(prog_wdata) | cws_pkg::CFG_UNIMPL))
        else $error("configuration word not written");

    prog_gate_a: assert property (@(posedge clk) disable iff (rst)
        !prog_mode |=> $stable(cfg_r) && !ack_r)
        else $error("configuration reached outside programming");

    upper_ones_a: assert property (@(posedge clk) disable iff (rst)
        cfg_r[15:12] == 4'hF)
        else $error("unimplemented bits not one");

    fcm_decode_a: assert property (@(posedge clk) disable iff (rst)
        ##1 feat_r.clock_fail_monitor_en == $past(cfg_r[cws_pkg::FCM_BIT]))
        else $error("clock fail monitor decode wrong");

    dmp_decode_a: assert property (@(posedge clk) disable iff (rst)
        ##1 feat_r.data_memory_protect == !$past(cfg_r[cws_pkg::DMP_BIT]))
        else $error("data protection polarity wrong");

    bor_mode_a: assert property (@(posedge clk) disable iff (rst)
        (cfg_r[9:8] == cws_pkg::BOR_RUN && sleeping_r) |=> !feat_r.brownout_en)
        else $error("brown-out active in sleep");

    release_a: assert property (@(posedge clk) disable iff (rst)
        $fell(core_reset_r) |-> $past(state_r) != cws_pkg::ST_POWER_UP_DELAY_TIMER
                                || $past(power_up_delay_timer_done))
        else $error("released before timers expired");

endmodule // cws_startup

/* rtl/cws_pkg.sv */
// Constants, types and decoding for the configuration word start-up block
// Summary of operation
// - Enabled power-up delay holds reset 64 ms nominal, after power-up and brown-out
// - Crystal modes stay in reset until oscillator start-up count ends
// - Brown-out asserts reset; power-up delay may extend it by 64 ms
// - Sleep ends on external reset, watchdog wake or enabled interrupt
// - Bit reads 0 when programmed, 1 when not; features decode from it
// - Configuration word lives at program memory word 2007h
// - Config space open only in programming mode; user code barred
// - Word bits 15 to 12 are unimplemented and always read as 1
// - Bit 11 set enables clock fail monitor, clear disables it
// - Bit 10 set enables two-speed switchover, clear disables it
// - Brown-out field: 11 on, 10 run only, 01 software, 00 off
// - Bit 7 clear enables data memory protection, set disables it
// - Bit 4 clear enables power-up delay timer, set disables it
// - Bit 3 set forces watchdog on, clear leaves it to software
// - Bit 5 picks external reset pin or digital input with reset idle
// - Bits 2 to 0 pick oscillator mode and clock-out pin use
package cws_pkg;

    // Configuration space map
    localparam logic [13:0] CFG_ADDR      = 14'h2007;
    localparam logic [13:0] CFG_SPACE_LO  = 14'h2000;
    localparam logic [13:0] CFG_SPACE_HI  = 14'h3FFF;
    localparam logic [15:0] CFG_ERASED    = 16'hFFFF;
    localparam logic [15:0] CFG_UNIMPL    = 16'hF000;
    localparam logic [15:0] CFG_UNMAPPED  = 16'h0000;

    // Field positions
    localparam int FCM_BIT  = 11;
    localparam int TSS_BIT  = 10;
    localparam int BOR_HI   = 9;
    localparam int BOR_LO   = 8;
    localparam int DMP_BIT  = 7;
    localparam int PMP_BIT  = 6;
    localparam int XRS_BIT  = 5;
    localparam int PUD_BIT  = 4;
    localparam int WDT_BIT  = 3;
    localparam int OSC_HI   = 2;

    // Brown-out select codes
    localparam logic [1:0] BOR_ON  = 2'h3;
    localparam logic [1:0] BOR_RUN = 2'h2;
    localparam logic [1:0] BOR_SW  = 2'h1;

    // Oscillator select codes
    localparam logic [2:0] OSC_RC      = 3'h7;
    localparam logic [2:0] OSC_INT_OUT = 3'h5;
    localparam logic [2:0] OSC_HS      = 3'h2;
    localparam logic [2:0] OSC_XT      = 3'h1;
    localparam logic [2:0] OSC_LPX     = 3'h0;

    // Timing
    localparam int CLK_HZ      = 10_000_000;
    localparam int POWER_UP_DELAY_TIMER_MS     = 64;
    localparam int POWER_UP_DELAY_TIMER_CYCLES = POWER_UP_DELAY_TIMER_MS * (CLK_HZ / 1000);
    localparam int OST_TICKS   = 1024;
    localparam int CNT_W       = 20;

    // Pin synchroniser reset: {osc, brown-out detect, reset pin}
    localparam logic [2:0] SYNC_RST = 3'h1;

    typedef struct packed {
        logic       clock_fail_monitor_en;
        logic       two_speed_switchover_en;
        logic       brownout_en;
        logic       data_memory_protect;
        logic       program_memory_protect;
        logic       ext_reset_pin_select;
        logic       power_up_delay_en;
        logic       watchdog_on;
        logic       clkout_en;
        logic       crystal_mode;
        logic [2:0] osc_mode;
    } cws_feat_t;

    typedef enum logic [2:0] {
        ST_HOLD,
        ST_POWER_UP_DELAY_TIMER,
        ST_OST,
        ST_RUN,
        ST_SLEEP
    } cws_state_t;

    function automatic cws_feat_t cws_decode(input logic [15:0] cfg,
                                             input logic        sleeping,
                                             input logic        sw_bor,
                                             input logic        sw_wdt);
        cws_feat_t f;
        f.clock_fail_monitor_en   = cfg[FCM_BIT];
        f.two_speed_switchover_en = cfg[TSS_BIT];
        case (cfg[BOR_HI:BOR_LO])
            BOR_ON:  f.brownout_en = 1'b1;
            BOR_RUN: f.brownout_en = ~sleeping;
            BOR_SW:  f.brownout_en = sw_bor;
            default: f.brownout_en = 1'b0;
        endcase
        f.data_memory_protect    = ~cfg[DMP_BIT];
        f.program_memory_protect = ~cfg[PMP_BIT];
        f.ext_reset_pin_select   = cfg[XRS_BIT];
        f.power_up_delay_en      = ~cfg[PUD_BIT];
        f.watchdog_on            = cfg[WDT_BIT] | sw_wdt;
        f.osc_mode               = cfg[OSC_HI:0];
        f.clkout_en    = (f.osc_mode == OSC_RC)
                       || (f.osc_mode == OSC_INT_OUT);
        f.crystal_mode = (f.osc_mode == OSC_LPX)
                       || (f.osc_mode == OSC_XT)
                       || (f.osc_mode == OSC_HS);
        return f;
    endfunction

endpackage

/* rtl/cws_delay.sv */
// Start-up delay counter that expires after a given number of ticks
`timescale 1ns/1ps
module cws_delay
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     clear,
    input  wire logic                     tick,
    input  wire logic [cws_pkg::CNT_W-1:0] limit,
    output logic                          done
);

    logic [cws_pkg::CNT_W-1:0] cnt_r;
    logic [cws_pkg::CNT_W-1:0] cnt_nxt;
    logic                      done_r;
    logic                      done_nxt;

    always_comb
    begin
        cnt_nxt  = cnt_r;
        done_nxt = done_r;
        if (clear)
        begin
            cnt_nxt  = '0;
            done_nxt = 1'b0;
        end
        else if (!done_r && tick)
        begin
            if (cnt_r == limit - 1'b1)
                done_nxt = 1'b1;
            else
                cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;

endmodule // cws_delay

/* tb/cws_prog.sv */
// Programmer model driving the configuration access port
`timescale 1ns/1ps
module cws_prog
(
    input  wire logic        clk,
    input  wire logic [15:0] prog_rdata,
    input  wire logic        prog_ack,
    output logic             prog_mode,
    output logic             prog_wr,
    output logic             prog_rd,
    output logic [13:0]      prog_addr,
    output logic [15:0]      prog_wdata
);
    initial
    begin
        prog_mode  = 1'b0;
        prog_wr    = 1'b0;
        prog_rd    = 1'b0;
        prog_addr  = 14'h0000;
        prog_wdata = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////
    // Mode change on a clock edge
    task automatic set_mode(input logic m);
        @(posedge clk);
        prog_mode <= m;
    endtask

    // One strobe, taken at the next edge, answer read after it
    task automatic access(input logic wr, input logic [13:0] a,
                          input logic [15:0] d, output logic [15:0] q,
                          output logic ack);
        @(posedge clk);
        prog_wr    <= wr;
        prog_rd    <= ~wr;
        prog_addr  <= a;
        prog_wdata <= d;
        @(posedge clk);
        prog_wr    <= 1'b0;
        prog_rd    <= 1'b0;
        prog_addr  <= ~a;
        prog_wdata <= ~d;
        #1;
        q   = prog_rdata;
        ack = prog_ack;
    endtask
endmodule // cws_prog

/* tb/tb_top.sv */
// Self-checking bench for the configuration word start-up block
`timescale 1ns/1ps
`define CHK(a, e) \
    begin \
        compares++; \
        if ((a) !== (e)) \
        begin \
            fails++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
        end \
    end
module tb_top;
    typedef struct packed {
        logic [15:0] w;
        logic        sb;
        logic        sw;
        logic [15:0] rd;
        logic [12:0] f;
    } cws_row_t;

    logic               clk;
    logic               rst;
    logic               ext_reset_pin_n;
    logic               brownout_det;
    logic               osc_pin;
    logic               sw_brownout_en;
    logic               sw_watchdog_en;
    logic               sleep_req;
    logic               watchdog_wake;
    logic               irq_wake;
    logic               prog_mode;
    logic               prog_wr;
    logic               prog_rd;
    logic [13:0]        prog_addr;
    logic [15:0]        prog_wdata;
    logic [15:0]        prog_rdata;
    logic               prog_ack;
    cws_pkg::cws_feat_t feat;
    logic               core_reset;
    logic               sleeping;
    logic               ext_pin_data;
    logic [15:0]        q;
    logic               ack;
    int                 n;
    int                 k;
    int                 fails;
    int                 compares;

    localparam cws_row_t ROWS [8] = '{
        '{16'h0000, 1'b1, 1'b0, 16'hF000, 13'h0348},
        '{16'h0DB5, 1'b1, 1'b1, 16'hFDB5, 13'h1DB5},
        '{16'h0A12, 1'b0, 1'b0, 16'hFA12, 13'h170A},
        '{16'h010F, 1'b0, 1'b0, 16'hF10F, 13'h0377},
        '{16'h03FE, 1'b0, 1'b0, 16'hF3FE, 13'h04A6},
        '{16'h03FC, 1'b0, 1'b0, 16'hF3FC, 13'h04A4},
        '{16'h03FB, 1'b0, 1'b0, 16'hF3FB, 13'h04A3},
        '{16'h03F9, 1'b0, 1'b0, 16'hF3F9, 13'h04A9}
    };

    cws_startup #(.POWER_UP_DELAY_TIMER_CYCLES(20), .OST_TICKS(4)) u_dut
    (
        .clk(clk), .rst(rst), .ext_reset_pin_n(ext_reset_pin_n),
        .brownout_det(brownout_det), .osc_pin(osc_pin),
        .sw_brownout_en(sw_brownout_en), .sw_watchdog_en(sw_watchdog_en),
        .sleep_req(sleep_req), .watchdog_wake(watchdog_wake),
        .irq_wake(irq_wake), .prog_mode(prog_mode), .prog_wr(prog_wr),
        .prog_rd(prog_rd), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
        .prog_rdata(prog_rdata), .prog_ack(prog_ack), .feat(feat),
        .core_reset(core_reset), .sleeping(sleeping),
        .ext_pin_data(ext_pin_data)
    );

    cws_prog u_prog
    (
        .clk(clk), .prog_rdata(prog_rdata), .prog_ack(prog_ack),
        .prog_mode(prog_mode), .prog_wr(prog_wr), .prog_rd(prog_rd),
        .prog_addr(prog_addr), .prog_wdata(prog_wdata)
    );

    always #50 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Bounded wait for the core reset level
    task automatic wait_core(input logic v, output int c);
        c = 0;
        while (core_reset !== v && c < 200)
        begin
            @(posedge clk);
            #1;
            c++;
        end
    endtask

    task automatic cfg_set(input logic [15:0] w, input logic go);
        u_prog.set_mode(1'b1);
        u_prog.access(1'b1, 14'h2007, w, q, ack);
        u_prog.set_mode(1'b0);
        if (go)
            wait_core(1'b0, n);
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        ext_reset_pin_n = 1'b1;
        brownout_det = 1'b0;
        osc_pin = 1'b0;
        sw_brownout_en = 1'b0;
        sw_watchdog_en = 1'b0;
        sleep_req = 1'b0;
        watchdog_wake = 1'b0;
        irq_wake = 1'b0;
        fails = 0;
        compares = 0;
        repeat (4) @(posedge clk);
        #1;
        `CHK(core_reset, 1'b1)
        `CHK(feat, 13'h1CB7)
        `CHK({prog_ack, sleeping, prog_rdata}, 18'h00000)
        @(posedge clk);
        rst <= 1'b0;
        wait_core(1'b0, n);
        `CHK(n < 6, 1'b1)
        // Decode table
        u_prog.set_mode(1'b1);
        foreach (ROWS[i])
        begin
            @(posedge clk);
            sw_brownout_en <= ROWS[i].sb;
            sw_watchdog_en <= ROWS[i].sw;
            u_prog.access(1'b1, 14'h2007, ROWS[i].w, q, ack);
            `CHK(ack, 1'b1)
            u_prog.access(1'b0, 14'h2007, 16'h0000, q, ack);
            `CHK(q, ROWS[i].rd)
            `CHK(feat, ROWS[i].f)
            `CHK(core_reset, 1'b1)
        end
        // Other addresses and refused strobes
        u_prog.access(1'b1, 14'h2006, 16'h0000, q, ack);
        `CHK(ack, 1'b1)
        u_prog.access(1'b0, 14'h2006, 16'hFFFF, q, ack);
        `CHK(q, 16'h0000)
        u_prog.access(1'b0, 14'h0007, 16'hFFFF, q, ack);
        `CHK(q, 16'h0000)
        u_prog.set_mode(1'b0);
        u_prog.access(1'b1, 14'h2007, 16'hFFFF, q, ack);
        `CHK(ack, 1'b0)
        u_prog.set_mode(1'b1);
        u_prog.access(1'b0, 14'h2007, 16'h0000, q, ack);
        `CHK(q, 16'hF3F9)
        // Brown-out with and without the power-up delay
        for (k = 0; k < 2; k++)
        begin
            cfg_set(k ? 16'h3FFF : 16'h3FEF, 1'b1);
            @(posedge clk);
            brownout_det <= ~brownout_det;
            wait_core(1'b1, n);
            `CHK(n < 8, 1'b1)
            @(posedge clk);
            brownout_det <= ~brownout_det;
            wait_core(1'b0, n);
            `CHK(k ? n < 8 : (n >= 20 && n < 32), 1'b1)
        end
        // Reset pin versus digital input use
        for (k = 0; k < 2; k++)
        begin
            cfg_set(k ? 16'h3FDF : 16'h3FFF, 1'b1);
            @(posedge clk);
            ext_reset_pin_n <= 1'b0;
            repeat (8) @(posedge clk);
            #1;
            `CHK(core_reset, k == 0)
            if (k)
                `CHK(ext_pin_data, 1'b0)
            @(posedge clk);
            ext_reset_pin_n <= 1'b1;
            wait_core(1'b0, n);
            `CHK(n < 8, 1'b1)
        end
        // Sleep and each wake source
        cfg_set(16'h3EFF, 1'b1);
        for (k = 0; k < 3; k++)
        begin
            @(posedge clk);
            sleep_req <= ~sleep_req;
            @(posedge clk);
            sleep_req <= ~sleep_req;
            #1;
            `CHK(sleeping, 1'b1)
            @(posedge clk);
            #1;
            `CHK(feat.brownout_en, 1'b0)
            @(posedge clk);
            irq_wake <= (k == 0);
            watchdog_wake <= (k == 1);
            ext_reset_pin_n <= (k != 2);
            repeat (6) @(posedge clk);
            #1;
            `CHK(sleeping, 1'b0)
            @(posedge clk);
            irq_wake <= 1'b0;
            watchdog_wake <= 1'b0;
            ext_reset_pin_n <= 1'b1;
            wait_core(1'b0, n);
        end
        // Crystal start-up waits for oscillator edges
        cfg_set(16'h3FF9, 1'b0);
        repeat (40) @(posedge clk);
        #1;
        `CHK(core_reset, 1'b1)
        repeat (5)
        begin
            @(posedge clk);
            osc_pin <= ~osc_pin;
            repeat (3) @(posedge clk);
            osc_pin <= ~osc_pin;
            repeat (2) @(posedge clk);
        end
        wait_core(1'b0, n);
        `CHK(n < 12, 1'b1)
        end_of_test();
    end
endmodule // tb_top
